// [rtl/sclk_map.svh]
`ifndef SCLK_MAP_SVH
`define SCLK_MAP_SVH

// register offsets (byte addresses on the plain register port)
`define SCLK_ADDR_SYSCTL 4'h0
`define SCLK_ADDR_PLLCTL 4'h4
`define SCLK_ADDR_PRESC 4'h8
`define SCLK_ADDR_STATUS 4'hC

// system control word fields
`define SCLK_SEL_LSB 0
`define SCLK_SEL_MSB 1

// pll control word fields
`define SCLK_BYP_BIT 0
`define SCLK_BAND_LSB 1
`define SCLK_BAND_MSB 2
`define SCLK_PLLIN_BIT 3
`define SCLK_PREIN_BIT 4
`define SCLK_K2_LSB 8
`define SCLK_K2_MSB 11
`define SCLK_P_LSB 12
`define SCLK_P_MSB 15
`define SCLK_N_LSB 16
`define SCLK_N_MSB 23

// prescaler word fields
`define SCLK_K1_LSB 0
`define SCLK_K1_MSB 9

// status word fields
`define SCLK_ST_SEL_LSB 0
`define SCLK_ST_SEL_MSB 1
`define SCLK_ST_BYP_BIT 2
`define SCLK_ST_PEND_BIT 3

// clock source select codes
`define SCLK_SRC_WAKEUP 2'h0
`define SCLK_SRC_RSVD 2'h1
`define SCLK_SRC_OSC 2'h2
`define SCLK_SRC_DIRECT 2'h3

// reset values
`define SCLK_RST_SEL 2'h0
`define SCLK_RST_BYP 1'h1
`define SCLK_RST_BAND 2'h0

// synchroniser lanes
`define SCLK_LANE_DIRECT 0
`define SCLK_LANE_XTAL 1
`define SCLK_LANE_ONCHIP 2
`define SCLK_LANE_WAKEUP 3

// pll accumulator ceiling
`define SCLK_ACC_MAX 16'hFFFF

`endif

// [rtl/sclk_pkg.sv]
`default_nettype none

package sclk_pkg;

  // switch-over state
  typedef enum logic [1:0] {
    SCLK_RUN = 2'b01,
    SCLK_WAIT = 2'b10
  } sclk_state_t;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sclk_bus_t;

  // clock generation settings
  typedef struct packed {
    logic [1:0] clock_source_select;
    logic vco_bypass;
    logic pll_input_select;
    logic prescaler_input_select;
    logic [9:0] prescaler_divider;
    logic [3:0] pll_output_divider;
    logic [3:0] pll_input_divider;
    logic [7:0] pll_multiplier;
  } sclk_cfg_t;

  // whole state of the selector
  typedef struct packed {
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [3:0] sync3_ff;
    sclk_cfg_t cfg_ff;
    sclk_cfg_t act_ff;
    logic [1:0] vco_band_select_ff;
    sclk_state_t state_ff;
    logic [9:0] pre_cnt_ff;
    logic [15:0] pll_acc_ff;
    logic [3:0] vco_cnt_ff;
    logic sys_ff;
    logic [31:0] rdata_ff;
  } sclk_state_reg_t;

endpackage : sclk_pkg

`default_nettype wire

// [rtl/sclk_selector.sv]
// What this block does
// - select code 11 passes the direct clock input straight through as system clock.
// - select 10 with bypass set gives oscillator divided by prescaler divider plus one.
// - prescaler source is selectable between crystal input and on-chip clock.
// - maximum prescaler divider value divides the oscillator by 1024.
// - divide ratio one passes the oscillator unchanged, same high and low times.
// - select 10 with bypass clear takes the system clock from the pll.
// - pll gives input times multiplier plus one over input and output divider terms.
// - pll input is selectable between crystal input and on-chip clock.
// - each system clock period spans output divider plus one vco cycles.
// - pll takes a new ratio at once at the hand-over; there is no gradual frequency slew.
// - band code 00 and 01 select vco ranges; codes 1X are reserved, never stored.
// - select code 00 runs the system clock from the wakeup clock.
`include "sclk_map.svh"
`default_nettype none

module sclk_selector (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST,
  // register port
  input wire sclk_pkg::sclk_bus_t I_BUS,
  output logic [31:0] O_RDATA,
  // clock source pins
  input wire logic I_DIRECT_CLOCK_INPUT,
  input wire logic I_CRYSTAL_INPUT,
  input wire logic I_ONCHIP_CLOCK,
  input wire logic I_WAKEUP_CLOCK,
  // generated clock and state
  output logic O_SYS_CLOCK,
  output logic [1:0] O_VCO_BAND,
  output logic [1:0] O_ACTIVE_SOURCE
);
  import sclk_pkg::*;

  // the whole state lives in one packed struct: q is the registered copy and n the next
  // value; keeping every flop in one place means one reset branch covers all of them,
  // at the cost of a wide comparison when the hand-over looks for a changed setting
  // limitation: the generated clock can toggle at most once per I_CLOCK edge
  sclk_state_reg_t q;
  sclk_state_reg_t n;

  // both transitions of a source count, so a divider sees two edges per source period
  // any change of a level between two samples is one edge
  function automatic logic edge_of(input logic cur, input logic prev);
    edge_of = cur ^ prev;
  endfunction : edge_of

  // level of the crystal or on-chip lane in the given synchroniser stage
  function automatic logic lane_level(input logic [3:0] s, input logic pick_onchip);
    lane_level = pick_onchip ? s[`SCLK_LANE_ONCHIP] : s[`SCLK_LANE_XTAL];
  endfunction : lane_level

  // helper values of the generators; all of them are cleared at the top of the
  // combinational process, so no latch can be inferred for a path that skips them
  logic osc_lvl;
  logic osc_edge;
  logic pll_edge;
  logic cand_low;
  logic vco_tick;
  logic [16:0] acc_sum;
  logic [16:0] acc_sub;
  logic [4:0] p_term;
  logic [8:0] n_term;

  // next-state logic for the whole block
  always_comb
  begin
    n = q;
    osc_lvl = 1'b0;
    osc_edge = 1'b0;
    pll_edge = 1'b0;
    cand_low = 1'b0;
    vco_tick = 1'b0;
    acc_sum = 17'h00000;
    acc_sub = 17'h00000;
    p_term = 5'h00;
    n_term = 9'h000;

    // the source pins are asynchronous to I_CLOCK and may be caught mid-transition;
    // two stages settle them, which costs two cycles of latency on every source,
    // and a source must stay below half the I_CLOCK rate to be seen at all
    // two flip-flops per pin; the third stage only feeds edge detection
    n.sync1_ff = {I_WAKEUP_CLOCK, I_ONCHIP_CLOCK, I_CRYSTAL_INPUT, I_DIRECT_CLOCK_INPUT};
    n.sync2_ff = q.sync1_ff;
    n.sync3_ff = q.sync2_ff;

    // register writes; a write changes the requested setting (the band code goes straight to its output), the running
    // generator keeps its old setting until the hand-over below swaps them, so
    // software may write the words in any order without a glitch on the output
    // register writes
    if (I_BUS.wr)
    begin
      case (I_BUS.addr)
        `SCLK_ADDR_SYSCTL:
        begin
          n.cfg_ff.clock_source_select = I_BUS.wdata[`SCLK_SEL_MSB:`SCLK_SEL_LSB];
        end
        `SCLK_ADDR_PLLCTL:
        begin
          n.cfg_ff.vco_bypass = I_BUS.wdata[`SCLK_BYP_BIT];
          n.cfg_ff.pll_input_select = I_BUS.wdata[`SCLK_PLLIN_BIT];
          n.cfg_ff.prescaler_input_select = I_BUS.wdata[`SCLK_PREIN_BIT];
          n.cfg_ff.pll_output_divider = I_BUS.wdata[`SCLK_K2_MSB:`SCLK_K2_LSB];
          n.cfg_ff.pll_input_divider = I_BUS.wdata[`SCLK_P_MSB:`SCLK_P_LSB];
          n.cfg_ff.pll_multiplier = I_BUS.wdata[`SCLK_N_MSB:`SCLK_N_LSB];
          // a reserved band code would leave the vco out of range, so it is dropped
          if (!I_BUS.wdata[`SCLK_BAND_MSB])
          begin
            n.vco_band_select_ff = I_BUS.wdata[`SCLK_BAND_MSB:`SCLK_BAND_LSB];
          end
        end
        `SCLK_ADDR_PRESC:
        begin
          n.cfg_ff.prescaler_divider = I_BUS.wdata[`SCLK_K1_MSB:`SCLK_K1_LSB];
        end
        default:
        begin
          n.cfg_ff = q.cfg_ff;
        end
      endcase
    end

    // the status word shows the setting in use, which lags the written one while a
    // hand-over is pending; software polls the pending bit before the next step
    // register reads, answered in the following cycle; unmapped reads give zero
    n.rdata_ff = 32'h00000000;
    if (I_BUS.rd)
    begin
      case (I_BUS.addr)
        `SCLK_ADDR_SYSCTL:
        begin
          n.rdata_ff[`SCLK_SEL_MSB:`SCLK_SEL_LSB] = q.cfg_ff.clock_source_select;
        end
        `SCLK_ADDR_PLLCTL:
        begin
          n.rdata_ff[`SCLK_BYP_BIT] = q.cfg_ff.vco_bypass;
          n.rdata_ff[`SCLK_BAND_MSB:`SCLK_BAND_LSB] = q.vco_band_select_ff;
          n.rdata_ff[`SCLK_PLLIN_BIT] = q.cfg_ff.pll_input_select;
          n.rdata_ff[`SCLK_PREIN_BIT] = q.cfg_ff.prescaler_input_select;
          n.rdata_ff[`SCLK_K2_MSB:`SCLK_K2_LSB] = q.cfg_ff.pll_output_divider;
          n.rdata_ff[`SCLK_P_MSB:`SCLK_P_LSB] = q.cfg_ff.pll_input_divider;
          n.rdata_ff[`SCLK_N_MSB:`SCLK_N_LSB] = q.cfg_ff.pll_multiplier;
        end
        `SCLK_ADDR_PRESC:
        begin
          n.rdata_ff[`SCLK_K1_MSB:`SCLK_K1_LSB] = q.cfg_ff.prescaler_divider;
        end
        `SCLK_ADDR_STATUS:
        begin
          n.rdata_ff[`SCLK_ST_SEL_MSB:`SCLK_ST_SEL_LSB] = q.act_ff.clock_source_select;
          n.rdata_ff[`SCLK_ST_BYP_BIT] = q.act_ff.vco_bypass;
          n.rdata_ff[`SCLK_ST_PEND_BIT] = (q.state_ff == SCLK_WAIT);
        end
        default:
        begin
          n.rdata_ff = 32'h00000000;
        end
      endcase
    end

    // oscillator as seen by the running generator
    osc_lvl = lane_level(q.sync2_ff, q.act_ff.prescaler_input_select);
    osc_edge = edge_of(osc_lvl, lane_level(q.sync3_ff, q.act_ff.prescaler_input_select));
    pll_edge = edge_of(lane_level(q.sync2_ff, q.act_ff.pll_input_select),
      lane_level(q.sync3_ff, q.act_ff.pll_input_select));

    // level the requested source would start with; divided sources restart low
    case (q.cfg_ff.clock_source_select)
      `SCLK_SRC_DIRECT:
      begin
        cand_low = !q.sync2_ff[`SCLK_LANE_DIRECT];
      end
      `SCLK_SRC_WAKEUP:
      begin
        cand_low = !q.sync2_ff[`SCLK_LANE_WAKEUP];
      end
      `SCLK_SRC_OSC:
      begin
        if (q.cfg_ff.vco_bypass && (q.cfg_ff.prescaler_divider == 10'h000))
        begin
          cand_low = !lane_level(q.sync2_ff, q.cfg_ff.prescaler_input_select);
        end
        else
        begin
          cand_low = 1'b1;
        end
      end
      default:
      begin
        cand_low = 1'b1;
      end
    endcase

    // only the active setting drives the output; pass-through sources add one
    // register stage after the synchroniser, divided sources toggle on counted edges,
    // and the reserved code holds the output low so nothing runs on an undefined clock
    // hazard: a stopped source freezes the output at its last level
    // clock generators of the active setting
    case (q.act_ff.clock_source_select)
      `SCLK_SRC_DIRECT:
      begin
        n.sys_ff = q.sync2_ff[`SCLK_LANE_DIRECT];
      end
      `SCLK_SRC_WAKEUP:
      begin
        n.sys_ff = q.sync2_ff[`SCLK_LANE_WAKEUP];
      end
      `SCLK_SRC_OSC:
      begin
        if (q.act_ff.vco_bypass)
        begin
          // each half period counts divider plus one oscillator edges
          if (q.act_ff.prescaler_divider == 10'h000)
          begin
            n.sys_ff = osc_lvl;
          end
          else if (osc_edge)
          begin
            if (q.pre_cnt_ff == q.act_ff.prescaler_divider)
            begin
              n.sys_ff = !q.sys_ff;
              n.pre_cnt_ff = 10'h000;
            end
            else
            begin
              n.pre_cnt_ff = q.pre_cnt_ff + 10'h001;
            end
          end
        end
        else
        begin
          // the accumulator stands in for the loop: rate is right on average, single
          // periods jitter by one I_CLOCK cycle, and a too fast ratio saturates
          // rather than skipping half cycles
          // input edges add multiplier plus one, vco half cycles take input divider plus one
          n_term = {1'b0, q.act_ff.pll_multiplier} + 9'h001;
          p_term = {1'b0, q.act_ff.pll_input_divider} + 5'h01;
          acc_sum = {1'b0, q.pll_acc_ff} + (pll_edge ? {8'h00, n_term} : 17'h00000);
          vco_tick = (acc_sum >= {12'h000, p_term});
          acc_sub = acc_sum - (vco_tick ? {12'h000, p_term} : 17'h00000);
          // at most one vco half cycle per clock: bursts are spread out, not passed on
          if (acc_sub > {1'b0, `SCLK_ACC_MAX})
          begin
            n.pll_acc_ff = `SCLK_ACC_MAX;
          end
          else
          begin
            n.pll_acc_ff = acc_sub[15:0];
          end
          if (vco_tick)
          begin
            if (q.vco_cnt_ff == q.act_ff.pll_output_divider)
            begin
              n.sys_ff = !q.sys_ff;
              n.vco_cnt_ff = 4'h0;
            end
            else
            begin
              n.vco_cnt_ff = q.vco_cnt_ff + 4'h1;
            end
          end
        end
      end
      default:
      begin
        n.sys_ff = 1'b0;
      end
    endcase

    // a new setting is only taken while the output is low and the new source would
    // also start low, so no high phase is ever cut short; the price
    // is that a source stuck high stalls the hand-over until it falls again
    // counters restart from zero so the first divided period is complete
    // hand-over: wait until both old and new clock are low, then restart
    case (q.state_ff)
      SCLK_RUN:
      begin
        if (q.cfg_ff != q.act_ff)
        begin
          n.state_ff = SCLK_WAIT;
        end
      end
      SCLK_WAIT:
      begin
        if (!q.sys_ff && cand_low)
        begin
          n.act_ff = q.cfg_ff;
          n.sys_ff = 1'b0;
          n.pre_cnt_ff = 10'h000;
          n.vco_cnt_ff = 4'h0;
          n.pll_acc_ff = 16'h0000;
          n.state_ff = SCLK_RUN;
        end
        else if (!q.sys_ff)
        begin
          n.sys_ff = 1'b0; // once low, hold low so no short high pulse escapes
        end
      end
      default:
      begin
        n.state_ff = SCLK_RUN;
      end
    endcase
  end

  // reset is synchronous: the source clocks keep running, so the selector falls back
  // to the wakeup source with the vco bypassed and every divider at zero
  // single state register
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      q <= '0;
      q.state_ff <= SCLK_RUN;
      q.cfg_ff.clock_source_select <= `SCLK_RST_SEL;
      q.cfg_ff.vco_bypass <= `SCLK_RST_BYP;
      q.act_ff.clock_source_select <= `SCLK_RST_SEL;
      q.act_ff.vco_bypass <= `SCLK_RST_BYP;
      q.vco_band_select_ff <= `SCLK_RST_BAND;
    end
    else
    begin
      q <= n;
    end
  end

  // no logic after the flops, so the generated clock carries no combinational glitch
  // outputs straight from flip-flops
  assign O_RDATA = q.rdata_ff;
  assign O_SYS_CLOCK = q.sys_ff;
  assign O_VCO_BAND = q.vco_band_select_ff;
  assign O_ACTIVE_SOURCE = q.act_ff.clock_source_select;

endmodule : sclk_selector

`default_nettype wire

// [verif/sclk_selector_assertions.sv]
`default_nettype none

module sclk_selector_checker (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST,
  // watched ports
  input wire sclk_pkg::sclk_bus_t I_BUS,
  input wire logic [31:0] O_RDATA,
  input wire logic I_DIRECT_CLOCK_INPUT,
  input wire logic I_WAKEUP_CLOCK,
  input wire logic O_SYS_CLOCK,
  input wire logic [1:0] O_VCO_BAND,
  input wire logic [1:0] O_ACTIVE_SOURCE
);
  import sclk_pkg::*;
  logic [2:0] run_ff;
  logic [2:0] nxt_run;

  // age since reset, so follow checks skip the flushing sync pipe
  always_comb nxt_run = I_RST ? 3'h0 : run_ff + {2'h0, run_ff != 3'h7};
  always_ff @(posedge I_CLOCK) run_ff <= nxt_run;

  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);

  // reset levels must show on every output
  a_reset_vals: assert property (disable iff (1'b0) I_RST |=> !O_SYS_CLOCK && O_RDATA == 32'h0
    && O_VCO_BAND == 2'h0 && O_ACTIVE_SOURCE == 2'h0) else $error("reset values wrong");
  a_rdata_idle: assert property (!$past(I_BUS.rd) |-> O_RDATA == 32'h0)
    else $error("read data outside read slot");
  a_band_legal: assert property (!O_VCO_BAND[1]) else $error("reserved band stored");
  a_band_store: assert property (I_BUS.wr && I_BUS.addr == 4'h4 && !I_BUS.wdata[2]
    |=> O_VCO_BAND == $past(I_BUS.wdata[2:1])) else $error("band not stored");
  a_band_hold: assert property ($changed(O_VCO_BAND)
    |-> $past(I_BUS.wr && I_BUS.addr == 4'h4)) else $error("band moved without write");
  a_reserved_low: assert property (O_ACTIVE_SOURCE == 2'h1 |-> !O_SYS_CLOCK)
    else $error("reserved select drives clock");
  // a change of the output must mirror the source three cycles back
  a_direct_follow: assert property (run_ff == 3'h7 && O_ACTIVE_SOURCE == 2'h3
    && $past(O_ACTIVE_SOURCE, 4) == 2'h3 && $changed(O_SYS_CLOCK)
    |-> O_SYS_CLOCK == $past(I_DIRECT_CLOCK_INPUT, 3)) else $error("direct not followed");
  a_wake_follow: assert property (run_ff == 3'h7 && O_ACTIVE_SOURCE == 2'h0
    && $past(O_ACTIVE_SOURCE, 4) == 2'h0 && $changed(O_SYS_CLOCK)
    |-> O_SYS_CLOCK == $past(I_WAKEUP_CLOCK, 3)) else $error("wakeup not followed");
  // switching while high would cut a pulse short
  a_handover_low: assert property ($changed(O_ACTIVE_SOURCE) |-> !$past(O_SYS_CLOCK))
    else $error("source switched while high");
endmodule : sclk_selector_checker

`default_nettype wire

// [verif/sclk_selector_tb_top.sv]
`default_nettype none

module sclk_selector_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sclk_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sclk_bus_t bus = '0;
  logic [3:0] src = 4'h0;
  logic [31:0] rdata;
  logic sys;
  logic [1:0] band;
  logic [1:0] act;
  int cyc = 0;
  int bad_count = 0;
  int comparisons = 0;
  logic [31:0] k1 [3] = '{32'h0, 32'h2, 32'h3FF};
  logic [31:0] pw [3] = '{32'h3, 32'h3, 32'h13};
  logic [31:0] lw [3] = '{32'h22102, 32'h52002, 32'h2210A};
  int pp [3] = '{6, 18, 10240};
  int lp [3] = '{12, 3, 20};

  sclk_selector uut (.I_CLOCK(clk), .I_RST(rst), .I_BUS(bus), .O_RDATA(rdata),
    .I_DIRECT_CLOCK_INPUT(src[0]), .I_CRYSTAL_INPUT(src[1]), .I_ONCHIP_CLOCK(src[2]),
    .I_WAKEUP_CLOCK(src[3]), .O_SYS_CLOCK(sys), .O_VCO_BAND(band), .O_ACTIVE_SOURCE(act));

  always #2.5 clk = ~clk;

  // sources: direct /8, crystal /6, on-chip /10, wakeup /14, all slow enough to sync
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    src <= src ^ {cyc % 7 == 0, cyc % 5 == 0, cyc % 3 == 0, cyc % 4 == 0};
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // an idle edge follows each strobe, so no signal is driven twice in one step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string name);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 check(name, exp, rdata);
    @(posedge clk);
  endtask : rd

  // the first two rises may belong to the hand-over, so the third period is judged
  task automatic period(input int exp, input string name);
    int t;
    logic p;
    repeat (3)
    begin
      t = 0;
      p = 1'b1;
      while (!(p === 1'b0 && sys === 1'b1) && t < 25000)
      begin
        p = sys;
        @(posedge clk);
        #1 t++;
      end
    end
    check(name, 32'(exp), 32'(t));
    @(posedge clk);
  endtask : period

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // watchdog: the /1024 run needs about 26000 cycles, the hand-over after it waits about 5000 more for its high phase, the rest a few hundred; 60000 allowed
  initial
  begin
    #300000;
    bad_count++;
    conclude();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(4'h0, 32'h0, "select");
    rd(4'h4, 32'h1, "pll word");
    rd(4'hC, 32'h4, "status");
    rd(4'h2, 32'h0, "unmapped");
    period(14, "wakeup");
    $display("test reset done");
    wr(4'h4, 32'h3);
    check("band", 32'h1, {30'h0, band});
    wr(4'h4, 32'h5);
    check("band", 32'h1, {30'h0, band});
    wr(4'hC, 32'h0);
    rd(4'h4, 32'h3, "pll word");
    $display("test band done");
    wr(4'h0, 32'h3);
    period(8, "direct");
    rd(4'hC, 32'h7, "status");
    $display("test direct done");
    // dividers are set before the select, so no stray divided clock appears
    for (int i = 0; i < 3; i++)
    begin
      wr(4'h8, k1[i]);
      wr(4'h4, pw[i]);
      wr(4'h0, 32'h2);
      period(pp[i], "prescaler");
    end
    $display("test prescaler done");
    for (int i = 0; i < 3; i++)
    begin
      wr(4'h4, lw[i]);
      period(lp[i], "pll");
    end
    $display("test pll done");
    wr(4'h0, 32'h1);
    repeat (40) @(posedge clk);
    #1 check("reserved clock", 32'h0, {31'h0, sys});
    rd(4'hC, 32'h1, "status");
    $display("test reserved done");
    conclude();
  end
endmodule : sclk_selector_tb_top

bind sclk_selector sclk_selector_checker chk (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_BUS(I_BUS),
  .O_RDATA(O_RDATA), .I_DIRECT_CLOCK_INPUT(I_DIRECT_CLOCK_INPUT),
  .I_WAKEUP_CLOCK(I_WAKEUP_CLOCK), .O_SYS_CLOCK(O_SYS_CLOCK), .O_VCO_BAND(O_VCO_BAND),
  .O_ACTIVE_SOURCE(O_ACTIVE_SOURCE));

`default_nettype wire
